// ---- include/gsp_pkg.sv ----
// package for the general purpose pad bank with network status indicator
// assumes a single 250 MHz clock and the plain strobe register port
package gsp_pkg;

    localparam int unsigned PAD_COUNT  = 10;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned STATUS_W   = 3;
    localparam int unsigned BLINK_W    = 30;

    // register byte offsets
    localparam logic [7:0] OFS_DIR      = 8'h00;
    localparam logic [7:0] OFS_ALT      = 8'h04;
    localparam logic [7:0] OFS_OUT      = 8'h08;
    localparam logic [7:0] OFS_LEVEL    = 8'h0C;
    localparam logic [7:0] OFS_PULL_EN  = 8'h10;
    localparam logic [7:0] OFS_PULL_UP  = 8'h14;
    localparam logic [7:0] OFS_NET      = 8'h18;
    localparam logic [7:0] OFS_IND      = 8'h1C;

    // reset values: inputs with pull-down enabled
    localparam logic [9:0] DIR_RST      = 10'h000;
    localparam logic [9:0] ALT_RST      = 10'h000;
    localparam logic [9:0] OUT_RST      = 10'h000;
    localparam logic [9:0] PULL_EN_RST  = 10'h3FF;
    localparam logic [9:0] PULL_UP_RST  = 10'h000;

    // pads that own an alternate function
    localparam int unsigned PAD_IND     = 0;
    localparam int unsigned PAD_RFMON   = 4;
    localparam logic [9:0] ALT_MASK     = 10'h011;

    // blink timing
    localparam int unsigned CLK_KHZ       = 250000;
    localparam int unsigned FAST_PERIOD_MS = 1000;
    localparam int unsigned FAST_ON_MS     = 500;
    localparam int unsigned SLOW_PERIOD_MS = 3000;
    localparam int unsigned SLOW_ON_MS     = 300;
    localparam int unsigned FAST_PERIOD_CYC = FAST_PERIOD_MS * CLK_KHZ;
    localparam int unsigned FAST_ON_CYC     = FAST_ON_MS * CLK_KHZ;
    localparam int unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_MS * CLK_KHZ;
    localparam int unsigned SLOW_ON_CYC     = SLOW_ON_MS * CLK_KHZ;

    typedef enum logic [2:0]
    {
        NET_OFF        = 3'h0,
        NET_SEARCH     = 3'h1,
        NET_UNREG      = 3'h2,
        NET_TURN_OFF   = 3'h3,
        NET_REGISTERED = 3'h4,
        NET_CALL       = 3'h5
    } gsp_net_type;

    typedef enum logic [1:0]
    {
        PAT_OFF  = 2'h0,
        PAT_FAST = 2'h1,
        PAT_SLOW = 2'h2,
        PAT_ON   = 2'h3
    } gsp_pat_type;

endpackage

// ---- sim/gsp_ext_dev.sv ----
// far side of the pads: external drivers, pulls and the pad wire level
// assumes pad controls come straight from gsp_port each cycle
`timescale 1ns/100ps
module gsp_ext_dev
(
    input  wire logic       clock_in,
    input  wire logic [9:0] drv_en_in,
    input  wire logic [9:0] drv_val_in,
    input  wire logic [9:0] pad_out_in,
    input  wire logic [9:0] oe_n_in,
    input  wire logic [9:0] pu_in,
    input  wire logic [9:0] pd_in,
    output logic      [9:0] level_out
);
    logic [9:0] last_r;

    always_ff @(posedge clock_in)
    begin
        last_r <= level_out;
    end

    // a floating wire shows the inverse of its last level, never a copy
    always_comb
    begin
        for (int i = 0; i < 10; i++)
        begin
            if (!oe_n_in[i])
                level_out[i] = pad_out_in[i];
            else if (drv_en_in[i])
                level_out[i] = drv_val_in[i];
            else if (pu_in[i] || pd_in[i])
                level_out[i] = pu_in[i];
            else
                level_out[i] = ~last_r[i];
        end
    end
endmodule

// ---- sim/gsp_port_checker.sv ----
// assertions on the pad bank register port and pad control outputs
// assumes it is bound onto gsp_port and sees only that module's ports
`timescale 1ns/100ps
module gsp_port_checker
    import gsp_pkg::*;
(
    input wire logic              clock_in,
    input wire logic              nrst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic [9:0]        pad_in,
    input wire logic [9:0]        pad_out,
    input wire logic [9:0]        pad_oe_n_out,
    input wire logic [9:0]        pull_up_out,
    input wire logic [9:0]        pull_down_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    AST_RD_IDLE: assert property (!rd_in |=> rdata_out == '0)
        else $error("read data not zero outside a read");
    AST_LEVEL: assert property (rd_in && addr_in == OFS_LEVEL |=>
        rdata_out[9:0] == (($past(pad_in) & $past(pad_oe_n_out))
        | ($past(pad_out) & ~$past(pad_oe_n_out))))
        else $error("level read differs from pad state");
    AST_DIR_WR: assert property (wr_in && addr_in == OFS_DIR |=> ##1
        ((pad_oe_n_out ^ ~$past(wdata_in[9:0], 2)) & ~ALT_MASK) == '0)
        else $error("direction write not applied");
    AST_OUT_WR: assert property (wr_in && addr_in == OFS_OUT |=> ##1
        ((pad_out ^ $past(wdata_in[9:0], 2)) & ~pad_oe_n_out
        & ~ALT_MASK) == '0)
        else $error("output write not driven");
    AST_RESET: assert property (!$past(nrst_in) |->
        pad_oe_n_out == 10'h3FF && pull_down_out == 10'h3FF
        && pull_up_out == 10'h000)
        else $error("pads not pulled-down inputs after reset");
    AST_NO_PULL: assert property
        ((~pad_oe_n_out & (pull_up_out | pull_down_out)) == '0)
        else $error("pull active on a driven pad");
    AST_PULL_ONE: assert property ((pull_up_out & pull_down_out) == '0)
        else $error("pull-up and pull-down together");
    AST_UNMAPPED: assert property (rd_in && addr_in >= 8'h20 |=>
        rdata_out == '0)
        else $error("unmapped read not zero");
    AST_ALT_MASK: assert property (rd_in && addr_in == OFS_ALT |=>
        (rdata_out[9:0] & ~ALT_MASK) == '0)
        else $error("alternate bit set on a plain pad");
endmodule

bind gsp_port gsp_port_checker gsp_port_checker_inst (
    .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n_out(pad_oe_n_out), .pull_up_out(pull_up_out),
    .pull_down_out(pull_down_out)
);

// ---- sim/gsp_port_tb.sv ----
// self-checking bench for the pad bank through its register port
// assumes gsp_port with shortened blink counts and gsp_ext_dev on pads
`timescale 1ns/100ps
module gsp_port_tb
    import gsp_pkg::*;
();
    localparam int unsigned FP = 20, FO = 10, SP = 30, SO = 3;
    logic              clock_in, nrst_in, wr, rd, sv, rf;
    logic [7:0]        addr;
    logic [31:0]       wdata, rdata, d;
    logic [9:0]        sdir, salt, sout, sen, sup, ext_en, ext_val;
    logic [9:0]        pad_in, pad_out, oe_n, pu, pd;
    int                fails, total_checks, lit;

    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    gsp_port #(.FAST_PERIOD(FP), .FAST_ON(FO), .SLOW_PERIOD(SP),
        .SLOW_ON(SO)) gsp_port_inst (.clock_in(clock_in),
        .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .saved_valid_in(sv),
        .saved_dir_in(sdir), .saved_alt_in(salt), .saved_out_in(sout),
        .saved_pull_en_in(sen), .saved_pull_up_in(sup),
        .rf_transmit_monitor_in(rf), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n_out(oe_n), .pull_up_out(pu), .pull_down_out(pd));

    gsp_ext_dev gsp_ext_dev_inst (.clock_in(clock_in), .drv_en_in(ext_en),
        .drv_val_in(ext_val), .pad_out_in(pad_out), .oe_n_in(oe_n),
        .pu_in(pu), .pd_in(pd), .level_out(pad_in));

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [9:0] v);
        @(posedge clock_in);
        addr <= a;
        wdata <= {22'h000000, v};
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic rst(input logic s);
        @(posedge clock_in);
        nrst_in <= 1'b0;
        sv <= s;
        repeat (3) @(posedge clock_in);
        nrst_in <= 1'b1;
        tick(3);
    endtask

    task automatic print_verdict();
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [1:0] pat(input logic [2:0] c);
        case (c)
            3'h1, 3'h2, 3'h3: return 2'h1;
            3'h4:             return 2'h2;
            3'h5:             return 2'h3;
            default:          return 2'h0;
        endcase
    endfunction

    // the led is lit while the pin is low; count lit cycles in one period
    task automatic blink(input logic [2:0] c, input int per);
        wr_reg(OFS_NET, 10'h000);
        wr_reg(OFS_NET, {7'h00, c});
        tick(3);
        chk({9'h000, pad_out[0]}, 10'h000);
        lit = 0;
        repeat (per)
        begin
            if (pad_out[0] === 1'b0)
                lit++;
            tick(1);
        end
    endtask

    initial
    begin
        {nrst_in, wr, rd, sv, rf, addr, wdata} = '0;
        {ext_en, ext_val, salt} = '0;
        {sdir, sout, sen, sup} = {10'h00F, 10'h005, 10'h3FF, 10'h300};
        rst(1'b0);
        chk(pd, 10'h3FF);
        chk(oe_n | pu, 10'h3FF);
        rd_reg(OFS_PULL_EN);
        chk(d[9:0], 10'h3FF);
        ext_en <= 10'h3FF;
        ext_val <= 10'h2B5;
        rd_reg(OFS_LEVEL);
        chk(d[9:0], 10'h2B5);
        ext_val <= 10'h14A;
        rd_reg(OFS_LEVEL);
        chk(d[9:0], 10'h14A);
        ext_en <= 10'h000;
        rd_reg(OFS_LEVEL);
        chk(d[9:0], 10'h000);
        wr_reg(OFS_PULL_UP, 10'h0F0);
        tick(2);
        chk(pu, 10'h0F0);
        chk(pd, 10'h30F);
        rd_reg(OFS_LEVEL);
        chk(d[9:0], 10'h0F0);
        wr_reg(OFS_DIR, 10'h3FF);
        wr_reg(OFS_OUT, 10'h2AA);
        tick(2);
        chk(oe_n | pu | pd, 10'h000);
        rd_reg(OFS_LEVEL);
        chk(d[9:0], 10'h2AA);
        wr_reg(8'h20, 10'h000);
        rd_reg(8'h20);
        chk(d[9:0], 10'h000);
        rd_reg(OFS_DIR);
        chk(d[9:0], 10'h3FF);
        wr_reg(OFS_DIR, 10'h000);
        wr_reg(OFS_ALT, 10'h3FF);
        rd_reg(OFS_ALT);
        chk(d[9:0], ALT_MASK);
        @(posedge clock_in);
        rf <= 1'b1;
        tick(2);
        chk({8'h00, oe_n[4], pad_out[4]}, 10'h001);
        @(posedge clock_in);
        rf <= 1'b0;
        tick(2);
        chk({8'h00, oe_n[4], pad_out[4]}, 10'h000);
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(OFS_NET, 10'(c));
            rd_reg(OFS_IND);
            chk({8'h00, d[2:1]}, {8'h00, pat(3'(c))});
        end
        wr_reg(OFS_NET, 10'h000);
        tick(3);
        chk({8'h00, oe_n[0], pad_out[0]}, 10'h001);
        // pattern, then led, then pin: three edges after the write
        wr_reg(OFS_NET, 10'h005);
        tick(3);
        chk({9'h000, pad_out[0]}, 10'h000);
        blink(3'h1, FP);
        chk(10'(lit), 10'(FO));
        blink(3'h4, SP);
        chk(10'(lit), 10'(SO));
        rst(1'b1);
        chk(oe_n, 10'h3F0);
        chk(pad_out & 10'h00F, 10'h005);
        chk(pu ^ pd, 10'h3F0);
        rd_reg(OFS_DIR);
        chk(d[9:0], 10'h00F);
        print_verdict();
    end

    initial
    begin
        #20000;
        fails++;
        print_verdict();
    end
endmodule

// ---- verilog/gsp_port.sv ----
// ten-pad general purpose port with pulls, readback and two alternates
// assumes pad levels arrive synchronous to clock_in and an external pad
// cell combines output, output enable and pull controls onto each wire
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps

// How it works
// - each pad: input or output; pads one and five also alternate
// - input read returns pad level now
// - output drives written level, reads back
// - pad one alternate carries status indicator
// - pad five alternate carries transmit monitor
// - per pad pull-up or pull-down select
// - start as pulled-down inputs unless saved
// - outputs drive push-pull both ways
// - indicator shows net and call, inverted
// - searching: 1s period, 0.5s on
// - registered: 3s period, 0.3s on
// - call on steady, device off dark
module gsp_port
    import gsp_pkg::*;
#(
    parameter int unsigned FAST_PERIOD = FAST_PERIOD_CYC,
    parameter int unsigned FAST_ON     = FAST_ON_CYC,
    parameter int unsigned SLOW_PERIOD = SLOW_PERIOD_CYC,
    parameter int unsigned SLOW_ON     = SLOW_ON_CYC
)
(
    input  wire logic                clock_in,
    input  wire logic                nrst_in,
    input  wire logic [ADDR_W-1:0]   addr_in,
    input  wire logic [DATA_W-1:0]   wdata_in,
    input  wire logic                wr_in,
    input  wire logic                rd_in,
    output logic      [DATA_W-1:0]   rdata_out,
    input  wire logic                saved_valid_in,
    input  wire logic [9:0]          saved_dir_in,
    input  wire logic [9:0]          saved_alt_in,
    input  wire logic [9:0]          saved_out_in,
    input  wire logic [9:0]          saved_pull_en_in,
    input  wire logic [9:0]          saved_pull_up_in,
    input  wire logic                rf_transmit_monitor_in,
    input  wire logic [9:0]          pad_in,
    output logic      [9:0]          pad_out,
    output logic      [9:0]          pad_oe_n_out,
    output logic      [9:0]          pull_up_out,
    output logic      [9:0]          pull_down_out
);

    localparam logic [BLINK_W-1:0] FAST_PER_C = BLINK_W'(FAST_PERIOD);
    localparam logic [BLINK_W-1:0] FAST_ON_C  = BLINK_W'(FAST_ON);
    localparam logic [BLINK_W-1:0] SLOW_PER_C = BLINK_W'(SLOW_PERIOD);
    localparam logic [BLINK_W-1:0] SLOW_ON_C  = BLINK_W'(SLOW_ON);
    localparam logic [BLINK_W-1:0] CNT_ONE    = {{(BLINK_W-1){1'b0}}, 1'b1};
    localparam logic [BLINK_W-1:0] CNT_ZERO   = {BLINK_W{1'b0}};

    logic [9:0]           dir_r;
    logic [9:0]           alt_r;
    logic [9:0]           out_r;
    logic [9:0]           pull_en_r;
    logic [9:0]           pull_up_r;
    gsp_net_type          net_r;
    logic                 load_pend_r;
    gsp_pat_type          pat_r;
    gsp_pat_type          pat_nxt;
    logic [BLINK_W-1:0]   blink_cnt_r;
    logic                 led_on_r;
    logic                 led_on_nxt;
    logic [9:0]           level_view;
    logic [9:0]           pad_nxt;
    logic [9:0]           drive_en;
    logic                 wr_hit;

    // widen a pad word to a bus word, upper bits read as zero
    function automatic logic [DATA_W-1:0] pad_word(input logic [9:0] v);
        pad_word = {{(DATA_W-10){1'b0}}, v};
    endfunction

    // led lit in the first on_cyc cycles of each period
    function automatic logic blink_lit(input logic [BLINK_W-1:0] cnt,
                                       input logic [BLINK_W-1:0] on_cyc);
        blink_lit = (cnt < on_cyc);
    endfunction

    // period length of a blinking pattern
    function automatic logic [BLINK_W-1:0] pat_period(input gsp_pat_type p);
        pat_period = (p == PAT_SLOW) ? SLOW_PER_C : FAST_PER_C;
    endfunction

    assign wr_hit = wr_in & ~load_pend_r;

    // restore of saved settings happens on the first edge after release;
    // under reset only constants load, so the saved word is never looked at
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            load_pend_r <= 1'b1;
        end
        else
        begin
            load_pend_r <= 1'b0;
        end
    end

    // direction per pad, 1 = output
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            dir_r <= DIR_RST;
        end
        else if (load_pend_r)
        begin
            if (saved_valid_in)
            begin
                dir_r <= saved_dir_in;
            end
        end
        else if (wr_hit && addr_in == OFS_DIR)
        begin
            dir_r <= wdata_in[9:0];
        end
    end

    // alternate select; only pads owning an alternate keep the bit
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            alt_r <= ALT_RST;
        end
        else if (load_pend_r)
        begin
            if (saved_valid_in)
            begin
                alt_r <= saved_alt_in & ALT_MASK;
            end
        end
        else if (wr_hit && addr_in == OFS_ALT)
        begin
            alt_r <= wdata_in[9:0] & ALT_MASK;
        end
    end

    // software output levels
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            out_r <= OUT_RST;
        end
        else if (load_pend_r)
        begin
            if (saved_valid_in)
            begin
                out_r <= saved_out_in;
            end
        end
        else if (wr_hit && addr_in == OFS_OUT)
        begin
            out_r <= wdata_in[9:0];
        end
    end

    // pull enable and pull direction, one bit per pad each
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pull_en_r <= PULL_EN_RST;
            pull_up_r <= PULL_UP_RST;
        end
        else if (load_pend_r)
        begin
            if (saved_valid_in)
            begin
                pull_en_r <= saved_pull_en_in;
                pull_up_r <= saved_pull_up_in;
            end
        end
        else if (wr_hit)
        begin
            if (addr_in == OFS_PULL_EN)
            begin
                pull_en_r <= wdata_in[9:0];
            end
            if (addr_in == OFS_PULL_UP)
            begin
                pull_up_r <= wdata_in[9:0];
            end
        end
    end

    // reported network and call state; unknown codes show as off
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            net_r <= NET_OFF;
        end
        else if (wr_hit && addr_in == OFS_NET)
        begin
            net_r <= gsp_net_type'(wdata_in[STATUS_W-1:0]);
        end
    end

    // pattern chosen from the reported state
    always_comb
    begin
        unique case (net_r)
            NET_OFF:        pat_nxt = PAT_OFF;
            NET_SEARCH:     pat_nxt = PAT_FAST;
            NET_UNREG:      pat_nxt = PAT_FAST;
            NET_TURN_OFF:   pat_nxt = PAT_FAST;
            NET_REGISTERED: pat_nxt = PAT_SLOW;
            NET_CALL:       pat_nxt = PAT_ON;
            default:        pat_nxt = PAT_OFF;
        endcase
    end

    // blink counter restarts whenever the pattern changes, so a new
    // pattern always begins with a full on phase; a move between states of one pattern does not restart it
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pat_r       <= PAT_OFF;
            blink_cnt_r <= CNT_ZERO;
        end
        else
        begin
            pat_r <= pat_nxt;
            if (pat_nxt != pat_r)
            begin
                blink_cnt_r <= CNT_ZERO;
            end
            else if (blink_cnt_r == pat_period(pat_r) - CNT_ONE)
            begin
                blink_cnt_r <= CNT_ZERO;
            end
            else
            begin
                blink_cnt_r <= blink_cnt_r + CNT_ONE;
            end
        end
    end

    always_comb
    begin
        unique case (pat_r)
            PAT_OFF:  led_on_nxt = 1'b0;
            PAT_FAST: led_on_nxt = blink_lit(blink_cnt_r, FAST_ON_C);
            PAT_SLOW: led_on_nxt = blink_lit(blink_cnt_r, SLOW_ON_C);
            PAT_ON:   led_on_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            led_on_r <= 1'b0;
        end
        else
        begin
            led_on_r <= led_on_nxt;
        end
    end

    // pad drive value: alternate sources replace the software level;
    // the indicator pin is inverted because an external transistor
    // turns the led on when the pin is low
    always_comb
    begin
        pad_nxt = out_r;
        if (alt_r[PAD_IND])
        begin
            pad_nxt[PAD_IND] = ~led_on_r;
        end
        if (alt_r[PAD_RFMON])
        begin
            pad_nxt[PAD_RFMON] = rf_transmit_monitor_in;
        end
    end

    assign drive_en = dir_r | alt_r;

    // output pads drive both levels, so no pull is needed on them
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pad_out      <= OUT_RST;
            pad_oe_n_out <= ~DIR_RST;
        end
        else
        begin
            pad_out      <= pad_nxt;
            pad_oe_n_out <= ~drive_en;
        end
    end

    // pulls act only on pads that are not driven
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pull_up_out   <= PULL_EN_RST & PULL_UP_RST;
            pull_down_out <= PULL_EN_RST & ~PULL_UP_RST;
        end
        else
        begin
            pull_up_out   <= pull_en_r & pull_up_r & ~drive_en;
            pull_down_out <= pull_en_r & ~pull_up_r & ~drive_en;
        end
    end

    // input pads show the pad now; driven pads show what they drive
    // follows the pad cell enable, so a read in the cycle after a direction
    // change reports what the wire really does
    assign level_view = (pad_in & pad_oe_n_out)
                      | (pad_out & ~pad_oe_n_out);

    // read data stand for the one cycle after the strobe
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rdata_out <= '0;
        end
        else if (rd_in)
        begin
            case (addr_in)
                OFS_DIR:     rdata_out <= pad_word(dir_r);
                OFS_ALT:     rdata_out <= pad_word(alt_r);
                OFS_OUT:     rdata_out <= pad_word(out_r);
                OFS_LEVEL:   rdata_out <= pad_word(level_view);
                OFS_PULL_EN: rdata_out <= pad_word(pull_en_r);
                OFS_PULL_UP: rdata_out <= pad_word(pull_up_r);
                OFS_NET:     rdata_out <= {{(DATA_W-STATUS_W){1'b0}}, net_r};
                OFS_IND:     rdata_out <= {{(DATA_W-3){1'b0}}, pat_r, led_on_r};
                default:     rdata_out <= '0;
            endcase
        end
        else
        begin
            rdata_out <= '0;
        end
    end

endmodule
